/* File: core/dfl_decoder_fusion.sv */
// Behaviour
// - Stores decode as one fused entry, later split into address and data.
// - Register-with-memory load-plus-operation instructions stay one fused micro-op.
// - Load-then-jump instructions, return included, are micro-fused.
// - Compare and test with immediate and memory operands are micro-fused.
// - Pointer-relative instructions with an extra immediate are not micro-fused.
// - Pointer-relative instructions needing the pointer for control flow are not fused.
// - Those unfused cases emit two micro-ops, only from decoder 0.
// - Pair head is compare-like in register, immediate or micro-fused memory form.
// - Pair tail is a conditional branch immediately following the head.
// - At most one fused pair per cycle plus three others, five peak.
// - A fused pair leaves as one single dispatched operation.
// - Memory-immediate compares never macro-fuse; other two-operand forms may.
// - First generation: test fuses with every conditional branch.
// - First generation: compare fuses only with carry or zero branches.
// - First generation: no macro-fusion in 64-bit mode.
// - Second generation: compare also fuses with signed compare branches.
// - Second generation: macro-fusion works in 64-bit mode too.
// - Third generation: test/and fuse with all; compare/add/sub skip overflow, sign, parity.
// - Third generation: increment/decrement fuse only with zero and signed branches.
`timescale 1ns/1ps
`default_nettype none

module dfl_decoder_fusion (
	input  wire logic                                      core_clk_in,
	input  wire logic                                      rst_n_in,
	input  wire logic [1:0]                                gen_sel_in,
	input  wire logic                                      long_mode_in,
	input  wire logic [dfl_pkg::NUM_SLOTS-1:0]             ins_valid_in,
	input  wire logic [dfl_pkg::NUM_SLOTS-1:0][3:0]        ins_op_in,
	input  wire logic [dfl_pkg::NUM_SLOTS-1:0][2:0]        ins_form_in,
	input  wire logic [dfl_pkg::NUM_SLOTS-1:0][2:0]        ins_cond_in,
	input  wire logic [dfl_pkg::NUM_SLOTS-1:0]             ins_pc_rel_in,
	input  wire logic                                      out_ready_in,
	output logic      [dfl_pkg::IDX_W-1:0]                 ins_take_out,
	output logic      [dfl_pkg::NUM_DEC-1:0]               dec_valid_out,
	output logic      [dfl_pkg::NUM_DEC-1:0][2:0]          dec_index_out,
	output logic      [dfl_pkg::NUM_DEC-1:0][3:0]          dec_op_out,
	output logic      [dfl_pkg::NUM_DEC-1:0][2:0]          dec_branch_cond_out,
	output logic      [dfl_pkg::NUM_DEC-1:0]               dec_micro_fused_out,
	output logic      [dfl_pkg::NUM_DEC-1:0]               dec_macro_fused_out,
	output logic      [dfl_pkg::NUM_DEC-1:0]               dec_split_store_out,
	output logic      [dfl_pkg::NUM_DEC-1:0][1:0]          dec_issue_uops_out,
	output logic      [dfl_pkg::CNT_W-1:0]                 macro_pair_total_out,
	output logic      [dfl_pkg::CNT_W-1:0]                 micro_fused_total_out
);

	logic [dfl_pkg::NUM_SLOTS-1:0]        slot_micro;
	logic [dfl_pkg::NUM_SLOTS-1:0]        slot_two_uop;
	logic [dfl_pkg::NUM_SLOTS-1:0]        slot_split;
	logic [dfl_pkg::NUM_SLOTS-1:0]        slot_macro;
	logic [dfl_pkg::NUM_SLOTS-1:0]        nxt_slot_valid;
	logic [dfl_pkg::NUM_SLOTS-1:0][3:0]   nxt_slot_op;
	logic [dfl_pkg::NUM_SLOTS-1:0][2:0]   nxt_slot_cond;

	logic [dfl_pkg::NUM_DEC-1:0]          walk_valid;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     walk_index;
	logic [dfl_pkg::NUM_DEC-1:0]          walk_pair;
	logic [dfl_pkg::IDX_W-1:0]            walk_take;
	logic                                 walk_pair_seen;
	logic [2:0]                           walk_micro_cnt;

	logic [dfl_pkg::NUM_DEC-1:0]          sel_valid;
	logic [dfl_pkg::NUM_DEC-1:0][3:0]     sel_op;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     sel_cond;
	logic [dfl_pkg::NUM_DEC-1:0]          sel_micro;
	logic [dfl_pkg::NUM_DEC-1:0]          sel_split;
	logic [dfl_pkg::NUM_DEC-1:0][1:0]     sel_uops;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     sel_tail_index;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     sel_head_cond;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     sel_tail_cond;
	logic [dfl_pkg::NUM_DEC-1:0]          sel_two_uop;

	logic                                 stage_busy;
	logic                                 stage_load;

	logic [dfl_pkg::NUM_DEC-1:0]          dec_valid_ff;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     dec_index_ff;
	logic [dfl_pkg::NUM_DEC-1:0][3:0]     dec_op_ff;
	logic [dfl_pkg::NUM_DEC-1:0][2:0]     dec_cond_ff;
	logic [dfl_pkg::NUM_DEC-1:0]          dec_micro_ff;
	logic [dfl_pkg::NUM_DEC-1:0]          dec_macro_ff;
	logic [dfl_pkg::NUM_DEC-1:0]          dec_split_ff;
	logic [dfl_pkg::NUM_DEC-1:0][1:0]     dec_uops_ff;
	logic [dfl_pkg::CNT_W-1:0]            macro_total_ff;
	logic [dfl_pkg::CNT_W-1:0]            micro_total_ff;

	logic [dfl_pkg::CNT_W-1:0]            macro_step;
	logic [dfl_pkg::CNT_W-1:0]            micro_step;
	logic [dfl_pkg::CNT_W-1:0]            nxt_macro_total;
	logic [dfl_pkg::CNT_W-1:0]            nxt_micro_total;

	// Each slot looks one slot ahead; the last slot has no successor in this window,
	// so a head sitting there is decoded this cycle as a single unfused instruction when an earlier pair lets the walk reach it.
	genvar g;
	generate
		for (g = 0; g < dfl_pkg::NUM_SLOTS; g++) begin : g_slot
			if (g < dfl_pkg::NUM_SLOTS - 1) begin : g_has_next
				assign nxt_slot_valid[g] = ins_valid_in[g+1];
				assign nxt_slot_op[g]    = ins_op_in[g+1];
				assign nxt_slot_cond[g]  = ins_cond_in[g+1];
			end else begin : g_no_next
				assign nxt_slot_valid[g] = 1'b0;
				assign nxt_slot_op[g]    = 4'h0;
				assign nxt_slot_cond[g]  = 3'h0;
			end

			dfl_slot_classify u_classify (
				.op_in           (ins_op_in[g]),
				.form_in         (ins_form_in[g]),
				.pc_rel_in       (ins_pc_rel_in[g]),
				.nxt_valid_in    (nxt_slot_valid[g]),
				.nxt_op_in       (nxt_slot_op[g]),
				.nxt_cond_in     (nxt_slot_cond[g]),
				.gen_sel_in      (gen_sel_in),
				.long_mode_in    (long_mode_in),
				.micro_fused_out (slot_micro[g]),
				.two_uop_d0_out  (slot_two_uop[g]),
				.split_store_out (slot_split[g]),
				.macro_first_out (slot_macro[g])
			);
		end
	endgenerate

	// In-order walk: each decoder takes one instruction or the single fused pair.
	// A two micro-op flow that would land past decoder 0 ends the group, so it
	// arrives at decoder 0 next cycle; this costs bandwidth but keeps order.
	always_comb begin
		logic [dfl_pkg::IDX_W-1:0] pos;
		logic                      stop;
		pos            = dfl_pkg::IDX_RESET;
		stop           = 1'b0;
		walk_valid     = '0;
		walk_index     = '0;
		walk_pair      = '0;
		walk_pair_seen = 1'b0;
		walk_micro_cnt = 3'h0;
		for (int d = 0; d < dfl_pkg::NUM_DEC; d++) begin
			if (!stop && (pos < dfl_pkg::SLOT_LIMIT) && ins_valid_in[pos]) begin
				if (slot_two_uop[pos] && (d != 0)) begin
					stop = 1'b1;
				end else if (slot_macro[pos] && !walk_pair_seen) begin
					walk_valid[d]  = 1'b1;
					walk_index[d]  = pos;
					walk_pair[d]   = 1'b1;
					walk_pair_seen = 1'b1;
					if (slot_micro[pos]) begin
						walk_micro_cnt = walk_micro_cnt + 3'h1;
					end
					pos = pos + dfl_pkg::STEP_PAIR;
				end else begin
					walk_valid[d] = 1'b1;
					walk_index[d] = pos;
					if (slot_micro[pos]) begin
						walk_micro_cnt = walk_micro_cnt + 3'h1;
					end
					pos = pos + dfl_pkg::STEP_ONE;
				end
			end
		end
		walk_take = pos;
	end

	// Field selection per decoder from the slot that it took.
	generate
		for (g = 0; g < dfl_pkg::NUM_DEC; g++) begin : g_sel
			assign sel_valid[g]      = walk_valid[g];
			assign sel_op[g]         = ins_op_in[walk_index[g]];
			assign sel_micro[g]      = walk_valid[g] && slot_micro[walk_index[g]];
			assign sel_split[g]      = walk_valid[g] && slot_split[walk_index[g]];
			// The tail slot is only meaningful for a pair, which never starts in the last slot.
			assign sel_tail_index[g] = walk_index[g] + dfl_pkg::STEP_ONE;
			assign sel_head_cond[g]  = ins_cond_in[walk_index[g]];
			assign sel_tail_cond[g]  = ins_cond_in[sel_tail_index[g]];
			assign sel_two_uop[g]    = slot_two_uop[walk_index[g]];
			// A pair carries its branch condition downstream with the single operation.
			assign sel_cond[g]       = walk_pair[g] ? sel_tail_cond[g] : sel_head_cond[g];
			assign sel_uops[g]       = !walk_valid[g] ? dfl_pkg::UOPS_NONE
				: (sel_two_uop[g] ? dfl_pkg::UOPS_TWO
				: dfl_pkg::UOPS_ONE);
		end
	endgenerate

	// The stage reloads when downstream accepts or when it holds nothing.
	// A held group takes nothing, so fetch must keep its window still while stalled.
	assign stage_busy   = |dec_valid_ff;
	assign stage_load   = out_ready_in || !stage_busy;
	assign ins_take_out = stage_load ? walk_take : dfl_pkg::IDX_RESET;

	assign macro_step      = {{(dfl_pkg::CNT_W-1){1'b0}}, walk_pair_seen};
	assign micro_step      = {{(dfl_pkg::CNT_W-3){1'b0}}, walk_micro_cnt};
	assign nxt_macro_total = macro_total_ff + macro_step;
	assign nxt_micro_total = micro_total_ff + micro_step;

	// Every stage register reloads on the same strobe, so a group never tears.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_valid_ff <= '0;
		end else if (stage_load) begin
			dec_valid_ff <= sel_valid;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_macro_ff <= '0;
		end else if (stage_load) begin
			dec_macro_ff <= walk_pair;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_index_ff <= '0;
		end else if (stage_load) begin
			dec_index_ff <= walk_index;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_op_ff <= '0;
		end else if (stage_load) begin
			dec_op_ff <= sel_op;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_cond_ff <= '0;
		end else if (stage_load) begin
			dec_cond_ff <= sel_cond;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_micro_ff <= '0;
		end else if (stage_load) begin
			dec_micro_ff <= sel_micro;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_split_ff <= '0;
		end else if (stage_load) begin
			dec_split_ff <= sel_split;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_uops_ff <= '0;
		end else if (stage_load) begin
			dec_uops_ff <= sel_uops;
		end
	end

	// Counters wrap; they are for performance sampling, not accounting.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			macro_total_ff <= dfl_pkg::CNT_RESET;
		end else if (stage_load) begin
			macro_total_ff <= nxt_macro_total;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			micro_total_ff <= dfl_pkg::CNT_RESET;
		end else if (stage_load) begin
			micro_total_ff <= nxt_micro_total;
		end
	end

	assign dec_valid_out         = dec_valid_ff;
	assign dec_index_out         = dec_index_ff;
	assign dec_op_out            = dec_op_ff;
	assign dec_branch_cond_out   = dec_cond_ff;
	assign dec_micro_fused_out   = dec_micro_ff;
	assign dec_macro_fused_out   = dec_macro_ff;
	assign dec_split_store_out   = dec_split_ff;
	assign dec_issue_uops_out    = dec_uops_ff;
	assign macro_pair_total_out  = macro_total_ff;
	assign micro_fused_total_out = micro_total_ff;

endmodule

`default_nettype wire

/* File: core/dfl_pkg.sv */
`default_nettype none

package dfl_pkg;

	localparam int unsigned NUM_SLOTS = 5;
	localparam int unsigned NUM_DEC   = 4;
	localparam int unsigned IDX_W     = 3;
	localparam int unsigned UOP_W     = 2;
	localparam int unsigned CNT_W     = 16;

	localparam logic [IDX_W-1:0] SLOT_LIMIT = 3'h5;
	localparam logic [IDX_W-1:0] STEP_ONE   = 3'h1;
	localparam logic [IDX_W-1:0] STEP_PAIR  = 3'h2;
	localparam logic [IDX_W-1:0] IDX_RESET  = 3'h0;
	localparam logic [UOP_W-1:0] UOPS_NONE  = 2'h0;
	localparam logic [UOP_W-1:0] UOPS_ONE   = 2'h1;
	localparam logic [UOP_W-1:0] UOPS_TWO   = 2'h2;
	localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;

	typedef enum logic [3:0] {
		DFL_OP_OTHER     = 4'h0,
		DFL_OP_STORE     = 4'h1,
		DFL_OP_LOAD_OP   = 4'h2,
		DFL_OP_LOAD_JUMP = 4'h3,
		DFL_OP_CMP       = 4'h4,
		DFL_OP_TEST      = 4'h5,
		DFL_OP_AND       = 4'h6,
		DFL_OP_ADD       = 4'h7,
		DFL_OP_SUB       = 4'h8,
		DFL_OP_INC       = 4'h9,
		DFL_OP_DEC       = 4'hA,
		DFL_OP_JCC       = 4'hB
	} dfl_op_e;

	typedef enum logic [2:0] {
		DFL_FORM_REG_ONLY               = 3'h0,
		DFL_FORM_REG_REG                = 3'h1,
		DFL_FORM_REGISTER_IMMEDIATE     = 3'h2,
		DFL_FORM_REG_MEM                = 3'h3,
		DFL_FORM_MEM_REG                = 3'h4,
		DFL_FORM_MEMORY_IMMEDIATE       = 3'h5,
		DFL_FORM_MEM_ONLY               = 3'h6
	} dfl_form_e;

	typedef enum logic [2:0] {
		DFL_CC_OVERFLOW_BRANCHES        = 3'h0,
		DFL_CC_CARRY_FLAG               = 3'h1,
		DFL_CC_ZERO_FLAG                = 3'h2,
		DFL_CC_CARRY_OR_ZERO            = 3'h3,
		DFL_CC_SIGN_PARITY_BRANCHES     = 3'h4,
		DFL_CC_SIGNED_COMPARE_BRANCHES  = 3'h5
	} dfl_cond_e;

	typedef enum logic [1:0] {
		DFL_GEN_FIRST  = 2'h0,
		DFL_GEN_SECOND = 2'h1,
		DFL_GEN_THIRD  = 2'h2
	} dfl_gen_e;

endpackage

`default_nettype wire

/* File: core/dfl_slot_classify.sv */
`timescale 1ns/1ps
`default_nettype none

module dfl_slot_classify (
	input  wire logic [3:0] op_in,
	input  wire logic [2:0] form_in,
	input  wire logic       pc_rel_in,
	input  wire logic       nxt_valid_in,
	input  wire logic [3:0] nxt_op_in,
	input  wire logic [2:0] nxt_cond_in,
	input  wire logic [1:0] gen_sel_in,
	input  wire logic       long_mode_in,
	output logic            micro_fused_out,
	output logic            two_uop_d0_out,
	output logic            split_store_out,
	output logic            macro_first_out
);
	dfl_pkg::dfl_op_e   op;
	dfl_pkg::dfl_form_e form;
	dfl_pkg::dfl_op_e   nxt_op;
	dfl_pkg::dfl_cond_e cc;
	logic               mem_form;
	logic               fusable_kind;
	logic               pc_block;
	logic               form_ok;
	logic               is_cmp_like;
	logic               is_logic;
	logic               is_step;
	logic               cc_cz;
	logic               cc_signed;
	logic               gen_ok;

	assign op     = dfl_pkg::dfl_op_e'(op_in);
	assign form   = dfl_pkg::dfl_form_e'(form_in);
	assign nxt_op = dfl_pkg::dfl_op_e'(nxt_op_in);
	assign cc     = dfl_pkg::dfl_cond_e'(nxt_cond_in);

	assign mem_form = (form == dfl_pkg::DFL_FORM_REG_MEM) || (form == dfl_pkg::DFL_FORM_MEM_REG)
		|| (form == dfl_pkg::DFL_FORM_MEMORY_IMMEDIATE) || (form == dfl_pkg::DFL_FORM_MEM_ONLY);

	assign is_logic    = (op == dfl_pkg::DFL_OP_TEST) || (op == dfl_pkg::DFL_OP_AND);
	assign is_cmp_like = (op == dfl_pkg::DFL_OP_CMP) || (op == dfl_pkg::DFL_OP_ADD)
		|| (op == dfl_pkg::DFL_OP_SUB);
	assign is_step     = (op == dfl_pkg::DFL_OP_INC) || (op == dfl_pkg::DFL_OP_DEC);

	assign fusable_kind = (op == dfl_pkg::DFL_OP_STORE)
		|| (op == dfl_pkg::DFL_OP_LOAD_OP)
		|| (op == dfl_pkg::DFL_OP_LOAD_JUMP)
		|| (op == dfl_pkg::DFL_OP_CMP) || (op == dfl_pkg::DFL_OP_TEST);

	assign pc_block = pc_rel_in && mem_form
		&& ((form == dfl_pkg::DFL_FORM_MEMORY_IMMEDIATE)
		|| (op == dfl_pkg::DFL_OP_LOAD_JUMP));

	assign micro_fused_out = mem_form && fusable_kind && !pc_block;
	assign two_uop_d0_out  = mem_form && fusable_kind && pc_block;
	assign split_store_out = micro_fused_out && (op == dfl_pkg::DFL_OP_STORE);

	// Memory operands qualify only when this instruction micro-fused on its own.
	assign form_ok = ((form == dfl_pkg::DFL_FORM_REG_REG)
		|| (form == dfl_pkg::DFL_FORM_REGISTER_IMMEDIATE)
		|| (form == dfl_pkg::DFL_FORM_REG_MEM)
		|| (form == dfl_pkg::DFL_FORM_MEM_REG)
		|| (is_step && (form == dfl_pkg::DFL_FORM_REG_ONLY)))
		&& (!mem_form || micro_fused_out);

	assign cc_cz = (cc == dfl_pkg::DFL_CC_CARRY_FLAG) || (cc == dfl_pkg::DFL_CC_ZERO_FLAG)
		|| (cc == dfl_pkg::DFL_CC_CARRY_OR_ZERO);
	assign cc_signed = (cc == dfl_pkg::DFL_CC_SIGNED_COMPARE_BRANCHES);

	always_comb begin
		unique case (gen_sel_in)
			dfl_pkg::DFL_GEN_FIRST: begin
				gen_ok = !long_mode_in
					&& ((op == dfl_pkg::DFL_OP_TEST)
					|| ((op == dfl_pkg::DFL_OP_CMP) && cc_cz));
			end
			dfl_pkg::DFL_GEN_SECOND: begin
				gen_ok = (op == dfl_pkg::DFL_OP_TEST)
					|| ((op == dfl_pkg::DFL_OP_CMP) && (cc_cz || cc_signed));
			end
			dfl_pkg::DFL_GEN_THIRD: begin
				gen_ok = is_logic
					|| (is_cmp_like && (cc_cz || cc_signed))
					|| (is_step && ((cc == dfl_pkg::DFL_CC_ZERO_FLAG) || cc_signed));
			end
			default: begin
				gen_ok = 1'b0;
			end
		endcase
	end

	assign macro_first_out = form_ok && gen_ok
		&& nxt_valid_in && (nxt_op == dfl_pkg::DFL_OP_JCC);

endmodule

`default_nettype wire

/* File: verification/dfl_decoder_fusion_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module dfl_decoder_fusion_bench;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [1:0]      gen = 2'h0;
	logic            lm = 1'b0;
	logic            slow = 1'b0;
	logic            rdy;
	logic [4:0]      vld = 5'h00;
	logic [4:0][3:0] op = 20'h00000;
	logic [4:0][2:0] fm = 15'h0000;
	logic [4:0][2:0] cc = 15'h0000;
	logic [4:0]      pcr = 5'h00;
	logic [2:0]      take;
	logic [3:0]      dv, dmic, dmac, dspl;
	logic [3:0][2:0] dix, dcc;
	logic [3:0][3:0] dop;
	logic [3:0][1:0] dup;
	logic [15:0]     ptot, mtot;
	int              n_fail = 0;
	int              n_checks = 0;

	dfl_sink_model u_sink (.core_clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .ready_out(rdy));

	dfl_decoder_fusion u_dut (
		.core_clk_in(clk), .rst_n_in(rst_n), .gen_sel_in(gen), .long_mode_in(lm),
		.ins_valid_in(vld), .ins_op_in(op), .ins_form_in(fm), .ins_cond_in(cc),
		.ins_pc_rel_in(pcr), .out_ready_in(rdy), .ins_take_out(take),
		.dec_valid_out(dv), .dec_index_out(dix), .dec_op_out(dop),
		.dec_branch_cond_out(dcc), .dec_micro_fused_out(dmic),
		.dec_macro_fused_out(dmac), .dec_split_store_out(dspl),
		.dec_issue_uops_out(dup), .macro_pair_total_out(ptot), .micro_fused_total_out(mtot)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Codes follow the package encodings of op class, operand form and branch class.
	task automatic put(input int s, input logic [3:0] o, input logic [2:0] f,
		input logic [2:0] c, input logic p);
		vld[s] = 1'b1;
		op[s] = o;
		fm[s] = f;
		cc[s] = c;
		pcr[s] = p;
	endtask

	task automatic step();
		@(posedge clk);
		@(negedge clk);
	endtask

	task automatic walk();
		gen = 2'h0;
		lm = 1'b0;
		vld = 5'h00;
		put(0, 4'h4, 3'h1, 3'h2, 1'b0);
		put(1, 4'hB, 3'h0, 3'h2, 1'b0);
		put(2, 4'h5, 3'h1, 3'h2, 1'b0);
		put(3, 4'hB, 3'h0, 3'h2, 1'b0);
		put(4, 4'h1, 3'h4, 3'h2, 1'b0);
		#1 chk("take peak", 16'h5, take);
		step();
		chk("valid", 16'hF, dv);
		chk("pair total", 16'h1, ptot);
		chk("micro total", 16'h1, mtot);
		chk("pairs", 16'h1, dmac);
		chk("index", {4'h0, 3'h4, 3'h3, 3'h2, 3'h0}, dix);
		chk("split", 16'h8, dspl);
		chk("uops", 16'h55, dup);
		vld = 5'h00;
	endtask

	task automatic pair(input logic [1:0] g, input logic l, input logic [3:0] o,
		input logic [2:0] f, input logic [2:0] c, input logic exp);
		gen = g;
		lm = l;
		vld = 5'h00;
		put(0, o, f, c, 1'b0);
		put(1, 4'hB, 3'h0, c, 1'b0);
		#1 chk("pair take", 16'h2, take);
		step();
		chk("fused", exp, dmac[0]);
		chk("tail valid", !exp, dv[1]);
		if (exp) begin
			chk("pair cond", c, dcc[0]);
		end else begin
			chk("tail index", 16'h1, dix[1]);
		end
		vld = 5'h00;
	endtask

	task automatic one(input logic [3:0] o, input logic [2:0] f, input logic p,
		input logic mic, input logic spl, input logic [1:0] up);
		gen = 2'h0;
		vld = 5'h00;
		put(0, o, f, 3'h2, p);
		step();
		chk("micro", mic, dmic[0]);
		chk("split", spl, dspl[0]);
		chk("issue", up, dup[0]);
		vld = 5'h00;
	endtask

	task automatic steer();
		vld = 5'h00;
		put(0, 4'h0, 3'h1, 3'h2, 1'b0);
		put(1, 4'h3, 3'h6, 3'h2, 1'b1);
		#1 chk("take before flow", 16'h1, take);
		step();
		vld = 5'h00;
		put(0, 4'h3, 3'h6, 3'h2, 1'b1);
		step();
		chk("flow issue", 16'h2, dup[0]);
		chk("flow micro", 16'h0, dmic[0]);
		vld = 5'h00;
	endtask

	task automatic stall();
		int k;
		vld = 5'h00;
		put(0, 4'h0, 3'h1, 3'h2, 1'b0);
		slow = 1'b1;
		k = 0;
		step();
		// Wait until this task's own group, not an earlier one, is the one being held.
		while ((rdy !== 1'b0 || dv[0] !== 1'b1 || dop[0] !== 4'h0) && k < 4) begin
			step();
			k++;
		end
		if (k == 4) begin
			n_fail++;
			$display("[ERR] stall wait expected held group seen none");
		end else begin
			chk("stalled take", 16'h0, take);
			op[0] = 4'h1;
			step();
			chk("held op", 16'h0, dop[0]);
			step();
			chk("released op", 16'h1, dop[0]);
			slow = 1'b0;
			vld = 5'h00;
		end
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		walk();
		pair(2'h0, 1'b0, 4'h5, 3'h1, 3'h0, 1'b1);
		pair(2'h0, 1'b0, 4'h5, 3'h2, 3'h4, 1'b1);
		pair(2'h0, 1'b0, 4'h4, 3'h2, 3'h3, 1'b1);
		pair(2'h0, 1'b0, 4'h4, 3'h1, 3'h5, 1'b0);
		pair(2'h0, 1'b1, 4'h4, 3'h1, 3'h1, 1'b0);
		pair(2'h0, 1'b0, 4'h7, 3'h1, 3'h2, 1'b0);
		pair(2'h1, 1'b0, 4'h4, 3'h1, 3'h5, 1'b1);
		pair(2'h1, 1'b1, 4'h4, 3'h1, 3'h2, 1'b1);
		pair(2'h1, 1'b0, 4'h4, 3'h5, 3'h2, 1'b0);
		pair(2'h1, 1'b0, 4'h4, 3'h4, 3'h2, 1'b1);
		pair(2'h2, 1'b0, 4'h6, 3'h1, 3'h0, 1'b1);
		pair(2'h2, 1'b0, 4'h7, 3'h1, 3'h4, 1'b0);
		pair(2'h2, 1'b0, 4'h8, 3'h2, 3'h1, 1'b1);
		pair(2'h2, 1'b0, 4'h9, 3'h0, 3'h2, 1'b1);
		pair(2'h2, 1'b0, 4'hA, 3'h0, 3'h1, 1'b0);
		pair(2'h2, 1'b0, 4'h9, 3'h0, 3'h5, 1'b1);
		pair(2'h3, 1'b0, 4'h4, 3'h1, 3'h2, 1'b0);
		one(4'h1, 3'h5, 1'b0, 1'b1, 1'b1, 2'h1);
		one(4'h2, 3'h3, 1'b0, 1'b1, 1'b0, 2'h1);
		one(4'h3, 3'h6, 1'b0, 1'b1, 1'b0, 2'h1);
		one(4'h5, 3'h5, 1'b0, 1'b1, 1'b0, 2'h1);
		one(4'h0, 3'h1, 1'b0, 1'b0, 1'b0, 2'h1);
		one(4'h4, 3'h5, 1'b1, 1'b0, 1'b0, 2'h2);
		steer();
		stall();
		tally_and_finish();
	end
endmodule

`default_nettype wire

/* File: verification/dfl_decoder_fusion_props.sv */
`timescale 1ns/1ps
`default_nettype none

module dfl_decoder_fusion_props (
	input wire logic            core_clk_in,
	input wire logic            rst_n_in,
	input wire logic [1:0]      gen_sel_in,
	input wire logic            long_mode_in,
	input wire logic            out_ready_in,
	input wire logic [2:0]      ins_take_out,
	input wire logic [3:0]      dec_valid_out,
	input wire logic [3:0][2:0] dec_index_out,
	input wire logic [3:0][3:0] dec_op_out,
	input wire logic [3:0]      dec_micro_fused_out,
	input wire logic [3:0]      dec_macro_fused_out,
	input wire logic [3:0]      dec_split_store_out,
	input wire logic [3:0][1:0] dec_issue_uops_out,
	input wire logic [15:0]     macro_pair_total_out
);
	logic load_w;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// The stage reloads whenever the sink takes it or it holds nothing.
	assign load_w = out_ready_in | ~|dec_valid_out;

	sequence s_held;
		(|dec_valid_out) && !out_ready_in;
	endsequence

	sequence s_first_long;
		load_w && gen_sel_in == dfl_pkg::DFL_GEN_FIRST && long_mode_in;
	endsequence

	chk_take_range: assert property (ins_take_out <= dfl_pkg::SLOT_LIMIT)
		else $error("take count above slot limit");
	chk_stall_take: assert property (s_held |-> ins_take_out == dfl_pkg::IDX_RESET)
		else $error("slots taken while stalled");
	chk_stall_hold: assert property (s_held |=> $stable(dec_valid_out)
		&& $stable(dec_index_out) && $stable(dec_op_out))
		else $error("group changed while stalled");
	chk_one_pair: assert property ($countones(dec_macro_fused_out) <= 1)
		else $error("more than one pair in a group");
	chk_steer_dec0: assert property (!(dec_issue_uops_out[1][1]
		| dec_issue_uops_out[2][1] | dec_issue_uops_out[3][1]))
		else $error("two-op flow outside decoder zero");
	chk_long_first: assert property (s_first_long |=> dec_macro_fused_out == 4'h0)
		else $error("pair formed in long mode on first generation");
	chk_pair_count: assert property (load_w |=> macro_pair_total_out
		== $past(macro_pair_total_out) + 16'($countones(dec_macro_fused_out)))
		else $error("pair total does not follow loaded pairs");

	for (genvar i = 0; i < 4; i++) begin : g_dec
		chk_split_store: assert property (dec_split_store_out[i] |-> dec_valid_out[i]
			&& dec_micro_fused_out[i] && dec_op_out[i] == dfl_pkg::DFL_OP_STORE)
			else $error("split flag on a non-store entry");
		chk_pair_single: assert property (dec_macro_fused_out[i] |-> dec_valid_out[i]
			&& dec_issue_uops_out[i] == dfl_pkg::UOPS_ONE)
			else $error("pair not issued as one operation");
	end
endmodule

bind dfl_decoder_fusion dfl_decoder_fusion_props u_props (
	.core_clk_in          (core_clk_in),
	.rst_n_in             (rst_n_in),
	.gen_sel_in           (gen_sel_in),
	.long_mode_in         (long_mode_in),
	.out_ready_in         (out_ready_in),
	.ins_take_out         (ins_take_out),
	.dec_valid_out        (dec_valid_out),
	.dec_index_out        (dec_index_out),
	.dec_op_out           (dec_op_out),
	.dec_micro_fused_out  (dec_micro_fused_out),
	.dec_macro_fused_out  (dec_macro_fused_out),
	.dec_split_store_out  (dec_split_store_out),
	.dec_issue_uops_out   (dec_issue_uops_out),
	.macro_pair_total_out (macro_pair_total_out)
);

`default_nettype wire

/* File: verification/dfl_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dfl_sink_model (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic slow_in,
	output logic      ready_out
);
	logic phase_ff;

	// A slow sink accepts on every other edge, so a held group must survive a stall.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
		end
	end

	assign ready_out = ~slow_in | phase_ff;
endmodule

`default_nettype wire
